// ==== hdl/uart_pkg.sv ====
/*
  package for the serial port: register addresses, control bit positions,
  reset values and the frame constants.
  assumes an 8-bit special-function-register bus on the processor side.
*/
package uart_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_ADDR = 8'h98;
  localparam logic [7:0] DATA_ADDR = 8'h99;

  // ----------------------------------------------------------------
  // control bit positions
  // ----------------------------------------------------------------
  localparam int FORMAT_BIT = 7;
  localparam int UNUSED_BIT = 6;
  localparam int MULTIPROC_BIT = 5;
  localparam int RX_ENABLE_BIT = 4;
  localparam int NINTH_TX_BIT = 3;
  localparam int NINTH_RX_BIT = 2;
  localparam int TX_DONE_BIT = 1;
  localparam int RX_DONE_BIT = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h40;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // frame timing, in ticks of sixteen per bit
  // ----------------------------------------------------------------
  localparam logic [3:0] TICKS_LAST = 4'hf;
  localparam logic [3:0] TICKS_MID = 4'h7;
  localparam logic [3:0] DATA_BITS_LAST = 4'h7;

  // sfr bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // received frame handed from the receiver
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic ninth;
    logic stop;
  } rx_frame_t;

endpackage : uart_pkg

// ==== hdl/uart_receiver.sv ====
/*
  serial receiver: finds the start bit, samples data at mid-bit and
  reports each complete frame as a one-cycle pulse.
  assumes rx_sync is already brought into the clock domain and that
  baud_tick comes sixteen times per bit.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_receiver
  import uart_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic baud_tick,
  input wire logic rx_sync,
  input wire logic nine_bit,
  input wire logic enable,
  output uart_pkg::rx_frame_t frame
);

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_NINTH = 3'b011,
    RX_STOP = 3'b100
  } rx_state_t;

  rx_state_t state_reg, state_next;
  logic [3:0] tick_reg, tick_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic ninth_reg, ninth_next;
  rx_frame_t frame_reg, frame_next;
  logic prev_reg;
  // start on a falling edge only, so a low stop bit cannot restart
  wire fall = prev_reg && !rx_sync;
  wire sample = baud_tick && (tick_reg == TICKS_MID);
  wire bit_end = baud_tick && (tick_reg == TICKS_LAST);

  always_comb begin
    state_next = state_reg;
    tick_next = baud_tick ? tick_reg + 4'h1 : tick_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    ninth_next = ninth_reg;
    frame_next = '0;
    unique case (state_reg)
      RX_IDLE: begin
        tick_next = '0;
        // no new frame starts while reception is off [RULE6]
        if (enable && fall) begin
          state_next = RX_START;
        end
      end
      RX_START: begin
        if (sample && rx_sync) begin
          state_next = RX_IDLE;
        end else if (bit_end) begin
          state_next = RX_DATA;
          bit_next = '0;
        end
      end
      RX_DATA: begin
        // lsb first [RULE2]
        if (sample) begin
          shift_next = {rx_sync, shift_reg[7:1]};
        end
        if (bit_end) begin
          bit_next = bit_reg + 4'h1;
          if (bit_reg == DATA_BITS_LAST) begin
            state_next = nine_bit ? RX_NINTH : RX_STOP;
          end
        end
      end
      RX_NINTH: begin
        if (sample) begin
          ninth_next = rx_sync;
        end
        if (bit_end) begin
          state_next = RX_STOP;
        end
      end
      RX_STOP: begin
        // frame reported at stop sampling [RULE10]
        if (sample) begin
          frame_next = '{valid: 1'b1, data: shift_reg, ninth: ninth_reg,
                         stop: rx_sync};
          state_next = RX_IDLE;
        end
      end
      default: state_next = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= RX_IDLE;
      tick_reg <= '0;
      bit_reg <= '0;
      shift_reg <= '0;
      ninth_reg <= 1'b0;
      frame_reg <= '0;
      prev_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      tick_reg <= tick_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      ninth_reg <= ninth_next;
      frame_reg <= frame_next;
      prev_reg <= rx_sync;
    end
  end

  assign frame = frame_reg;

endmodule : uart_receiver
`default_nettype wire

// ==== hdl/uart_control_and_buffer.sv ====
/*
  serial port zero: control register, data buffer, transmitter, and the
  receive acceptance logic around the receiver module.
  assumes a single-cycle sfr bus from the processor, a timer 1 overflow
  tick at sixteen times the bit rate, and an asynchronous rx pin.
*/
// What this block does
// [RULE1] format bit: clear selects 8-bit frames, set selects 9-bit frames.
// [RULE2] 9-bit frame: start, eight data lsb first, ninth bit, stop.
// [RULE3] frame loaded only if receive flag clear and multiproc check passes.
// [RULE4] 8-bit mode with multiproc bit set needs a high stop bit.
// [RULE5] 9-bit mode with multiproc bit set needs a high ninth bit.
// [RULE6] receive enable low stops new frames from starting; a frame already under way still completes. High allows reception.
// [RULE7] 9-bit mode sends the ninth transmit bit; 8-bit mode ignores it.
// [RULE8] ninth receive bit takes stop bit in 8-bit, ninth bit in 9-bit.
// [RULE9] transmit flag after eighth bit, or at stop start in 9-bit mode.
// [RULE10] receive flag sets when the stop bit is sampled.
// [RULE11] either flag set raises the interrupt request while enabled.
// [RULE12] flags are cleared only by software writing zero.
// [RULE13] data buffer write loads the shifter and starts transmission.
// [RULE14] data buffer read returns the receive latch, never tx data.
// [RULE15] software picks timer 1 reload for the wanted bit rate.
// [RULE16] bit timing advances only on the timer 1 overflow tick.
`timescale 1ns/1ps
`default_nettype none
module uart_control_and_buffer
  import uart_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire uart_pkg::sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic timer1_tick,
  input wire logic irq_enable,
  output logic irq_request,
  input wire logic rx_pin,
  output logic tx_pin
);

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_NINTH = 3'b011,
    TX_STOP = 3'b100
  } tx_state_t;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] control_reg, control_next;
  logic [7:0] rx_latch_reg, rx_latch_next;
  logic [7:0] tx_shift_reg, tx_shift_next;
  tx_state_t tx_state_reg, tx_state_next;
  logic [3:0] tx_tick_reg, tx_tick_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic tx_pin_reg, tx_pin_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg;
  logic rx_meta_reg, rx_sync_reg;
  rx_frame_t rx_frame;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire nine_bit = control_reg[FORMAT_BIT]; // [RULE1]
  wire multiproc = control_reg[MULTIPROC_BIT];
  wire ctl_wr = sfr_req.wr && (sfr_req.addr == CONTROL_ADDR);
  wire data_wr = sfr_req.wr && (sfr_req.addr == DATA_ADDR);
  wire ctl_rd = sfr_req.rd && (sfr_req.addr == CONTROL_ADDR);
  wire data_rd = sfr_req.rd && (sfr_req.addr == DATA_ADDR);
  wire tx_bit_end = timer1_tick && (tx_tick_reg == TICKS_LAST); // [RULE16]
  wire tx_last_data = tx_bit_end && (tx_bit_reg == DATA_BITS_LAST);
  // tx done: after bit eight in 8-bit mode, stop start in 9-bit [RULE9]
  wire tx_done_evt = nine_bit ? (tx_state_reg == TX_NINTH && tx_bit_end)
                              : (tx_state_reg == TX_DATA && tx_last_data);
  // multiproc check: stop bit in 8-bit, ninth bit in 9-bit [RULE4] [RULE5]
  wire mp_ok = !multiproc || (nine_bit ? rx_frame.ninth : rx_frame.stop);
  // accept only into a clear flag [RULE3]
  wire rx_accept = rx_frame.valid && !control_reg[RX_DONE_BIT] && mp_ok;
  // ninth receive bit source [RULE8]
  wire ninth_rx_val = nine_bit ? rx_frame.ninth : rx_frame.stop;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_comb begin
    control_next = control_reg;
    if (ctl_wr) begin
      control_next = sfr_req.wdata;
      control_next[UNUSED_BIT] = 1'b1;
    end
    // hardware only sets the flags, set beats a clearing write [RULE12]
    if (tx_done_evt) begin
      control_next[TX_DONE_BIT] = 1'b1;
    end
    if (rx_accept) begin
      control_next[NINTH_RX_BIT] = ninth_rx_val; // [RULE8]
      control_next[RX_DONE_BIT] = 1'b1; // [RULE10]
    end
  end

  assign rx_latch_next = rx_accept ? rx_frame.data : rx_latch_reg; // [RULE3]

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // data read sees the receive latch only [RULE14]
  assign rdata_next = ctl_rd ? control_next :
                      data_rd ? rx_latch_reg : 8'h00;

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_shift_next = tx_shift_reg;
    tx_bit_next = tx_bit_reg;
    tx_tick_next = timer1_tick ? tx_tick_reg + 4'h1 : tx_tick_reg;
    tx_pin_next = tx_pin_reg;
    unique case (tx_state_reg)
      TX_IDLE: begin
        tx_pin_next = 1'b1;
        tx_tick_next = '0;
      end
      TX_START: begin
        tx_pin_next = 1'b0;
        if (tx_bit_end) begin
          tx_state_next = TX_DATA;
          tx_bit_next = '0;
          tx_pin_next = tx_shift_reg[0];
        end
      end
      TX_DATA: begin
        // lsb first [RULE2]
        if (tx_bit_end) begin
          tx_bit_next = tx_bit_reg + 4'h1;
          tx_shift_next = {1'b0, tx_shift_reg[7:1]};
          tx_pin_next = tx_shift_reg[1];
          if (tx_last_data) begin
            tx_state_next = nine_bit ? TX_NINTH : TX_STOP;
            // ninth bit only in 9-bit mode [RULE7]
            tx_pin_next = nine_bit ? control_reg[NINTH_TX_BIT] : 1'b1;
          end
        end
      end
      TX_NINTH: begin
        if (tx_bit_end) begin
          tx_state_next = TX_STOP;
          tx_pin_next = 1'b1;
        end
      end
      TX_STOP: begin
        tx_pin_next = 1'b1;
        if (tx_bit_end) begin
          tx_state_next = TX_IDLE;
        end
      end
      default: tx_state_next = TX_IDLE;
    endcase
    // a buffer write loads and starts at once [RULE13]
    if (data_wr) begin
      tx_shift_next = sfr_req.wdata;
      tx_state_next = TX_START;
      tx_tick_next = '0;
      tx_pin_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  uart_receiver rx_unit (
    .clk(clk),
    .rst_n(rst_n),
    .baud_tick(timer1_tick), // [RULE16]
    .rx_sync(rx_sync_reg),
    .nine_bit(nine_bit),
    .enable(control_reg[RX_ENABLE_BIT]), // [RULE6]
    .frame(rx_frame)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control_reg <= CONTROL_RESET;
      rx_latch_reg <= DATA_RESET;
      tx_shift_reg <= DATA_RESET;
      tx_state_reg <= TX_IDLE;
      tx_tick_reg <= '0;
      tx_bit_reg <= '0;
      tx_pin_reg <= 1'b1;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      control_reg <= control_next;
      rx_latch_reg <= rx_latch_next;
      tx_shift_reg <= tx_shift_next;
      tx_state_reg <= tx_state_next;
      tx_tick_reg <= tx_tick_next;
      tx_bit_reg <= tx_bit_next;
      tx_pin_reg <= tx_pin_next;
      rdata_reg <= rdata_next;
      // request follows either flag while enabled [RULE11]
      irq_reg <= irq_enable &&
                 (control_next[TX_DONE_BIT] || control_next[RX_DONE_BIT]);
      rx_meta_reg <= rx_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign irq_request = irq_reg;
  assign tx_pin = tx_pin_reg;

endmodule : uart_control_and_buffer
`default_nettype wire

// ==== test/remote_uart.sv ====
/*
  far-end serial transceiver: sends frames on the rx line, captures tx.
  assumes a tick of sixteen per bit on the same clock as the device.
*/
`timescale 1ns/1ps
`default_nettype none
module remote_uart (
  input wire logic clk,
  input wire logic tick,
  input wire logic serial_in,
  output logic serial_out
);
  // ------------------------------------------------------------
  // frame tasks
  // ------------------------------------------------------------
  initial serial_out = 1'b1;

  task automatic bit_time(input logic v);
    serial_out <= v;
    repeat (16) @(posedge clk iff tick);
  endtask : bit_time

  // start, data lsb first, optional ninth, stop, idle high
  task automatic send(input logic [7:0] d, input logic nb, input logic n9,
                      input logic stp);
    bit_time(1'b0);
    for (int i = 0; i < 8; i++) bit_time(d[i]);
    if (nb) bit_time(n9);
    bit_time(stp);
    serial_out <= 1'b1;
  endtask : send

  // mid-bit sampling, d[8] is ninth or stop
  task automatic recv(output logic [8:0] d);
    @(negedge serial_in);
    repeat (8) @(posedge clk iff tick);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge clk iff tick);
      d[i] = serial_in;
    end
  endtask : recv
endmodule : remote_uart
`default_nettype wire

// ==== test/uart_control_and_buffer_properties.sv ====
/*
  checker for the serial port: bus reads, interrupt and tx timing.
  assumes it is bound to uart_control_and_buffer.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_control_and_buffer_properties
  import uart_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire uart_pkg::sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic timer1_tick,
  input wire logic irq_enable,
  input wire logic irq_request,
  input wire logic rx_pin,
  input wire logic tx_pin
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic data_wr = sfr_req.wr && sfr_req.addr == DATA_ADDR;
  wire logic ctrl_wr = sfr_req.wr && sfr_req.addr == CONTROL_ADDR;
  wire logic ctrl_rd = sfr_req.rd && sfr_req.addr == CONTROL_ADDR;
  wire logic mapped = sfr_req.addr == CONTROL_ADDR ||
                      sfr_req.addr == DATA_ADDR;
  sequence start_bit;
    !tx_pin [*2];
  endsequence

  chk_tx_start_low: assert property (data_wr |=> start_bit)
    else $error("tx start bit missing after data write");
  chk_tx_on_tick: assert property
    ($changed(tx_pin) |-> $past(timer1_tick) || $past(data_wr))
    else $error("tx changed without a tick");
  chk_irq_cause: assert property (irq_request |-> $past(irq_enable))
    else $error("irq without enable");
  chk_irq_off: assert property (!irq_enable |=> !irq_request)
    else $error("irq while disabled");
  chk_flag_hold: assert property
    (irq_request && irq_enable && !ctrl_wr |=> irq_request)
    else $error("flag dropped without software write");
  chk_rdata_idle: assert property (!sfr_req.rd |=> sfr_rdata == 8'h00)
    else $error("read data not zero when idle");
  chk_unmapped_zero: assert property
    (sfr_req.rd && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_ctrl_bit6: assert property (ctrl_rd |=> sfr_rdata[UNUSED_BIT])
    else $error("control bit 6 reads zero");
endmodule : uart_control_and_buffer_properties
`default_nettype wire

bind uart_control_and_buffer uart_control_and_buffer_properties chk (
  .clk(clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .timer1_tick(timer1_tick), .irq_enable(irq_enable),
  .irq_request(irq_request), .rx_pin(rx_pin), .tx_pin(tx_pin));

// ==== test/uart_control_and_buffer_tb.sv ====
/*
  testbench for the serial port: register access, transmit and receive.
  assumes remote_uart as far end and a tick on every other clock.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_control_and_buffer_tb;
  import uart_pkg::*;
  // ------------------------------------------------------------
  // bench
  // ------------------------------------------------------------
  logic clk, rst_n, irq_en, irq, rx, tx;
  logic tick = 1'b0;
  sfr_req_t req;
  logic [7:0] rdata, q;
  logic [8:0] got;
  int fails = 0;
  int cmp_count = 0;
  logic [7:0] tc[3] = '{8'h00, 8'h80, 8'h88};
  logic [7:0] td[3] = '{8'ha5, 8'h3c, 8'hc3};
  // control, data, ninth, stop, expected control, expected latch
  logic [33:0] rxr[8] = '{
    {8'h90, 8'h5a, 2'b11, 8'hd5, 8'h5a}, {8'h91, 8'h11, 2'b11, 8'hd1, 8'h5a},
    {8'hb0, 8'h22, 2'b01, 8'hf0, 8'h5a}, {8'hb0, 8'h33, 2'b11, 8'hf5, 8'h33},
    {8'h30, 8'h44, 2'b00, 8'h70, 8'h33}, {8'h30, 8'h55, 2'b01, 8'h75, 8'h55},
    {8'h10, 8'h66, 2'b00, 8'h51, 8'h66}, {8'h00, 8'h77, 2'b01, 8'h40, 8'h66}};

  uart_control_and_buffer dut (.clk(clk), .rst_n(rst_n), .sfr_req(req),
    .sfr_rdata(rdata), .timer1_tick(tick), .irq_enable(irq_en),
    .irq_request(irq), .rx_pin(rx), .tx_pin(tx));
  remote_uart far (.clk(clk), .tick(tick), .serial_in(tx), .serial_out(rx));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // timer 1 overflow stand-in, shortened
  always @(posedge clk) tick <= ~tick;

  task automatic check(input string n, input logic [8:0] e,
                       input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    d = rdata;
  endtask : rd

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  initial begin
    logic [7:0] c, d, ec, ed;
    logic n, s;
    rst_n = 1'b0;
    irq_en = 1'b1;
    req = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(CONTROL_ADDR, q);
    check("control reset", CONTROL_RESET, q);
    rd(DATA_ADDR, q);
    check("data reset", DATA_RESET, q);
    rd(8'h9a, q);
    check("unmapped", 8'h00, q);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      wr(CONTROL_ADDR, tc[i]);
      fork
        far.recv(got);
        wr(DATA_ADDR, td[i]);
      join
      check("tx frame", {tc[i][7] ? tc[i][3] : 1'b1, td[i]}, got);
      check("tx flag early", !tc[i][7], irq);
      repeat (24) @(posedge clk iff tick);
      rd(CONTROL_ADDR, q);
      check("tx flag", tc[i] | 8'h42, q);
      check("irq", 1'b1, irq);
    end
    rd(DATA_ADDR, q);
    check("latch after tx", 8'h00, q);
    $display("test transmit done");
    for (int i = 0; i < 8; i++) begin
      {c, d, n, s, ec, ed} = rxr[i];
      wr(CONTROL_ADDR, c);
      far.send(d, c[7], n, s);
      repeat (4) @(posedge clk);
      rd(CONTROL_ADDR, q);
      check("rx control", ec, q);
      rd(DATA_ADDR, q);
      check("rx latch", ed, q);
    end
    $display("test receive done");
    wr(CONTROL_ADDR, 8'h01);
    irq_en <= 1'b0;
    repeat (3) @(posedge clk);
    check("irq masked", 1'b0, irq);
    irq_en <= 1'b1;
    repeat (3) @(posedge clk);
    check("irq unmasked", 1'b1, irq);
    $display("test interrupt done");
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
endmodule : uart_control_and_buffer_tb
`default_nettype wire
